// File: hdl/flash_powerup_if.sv
// serial flash slave front end: power-up state, mode detect, command capture
`timescale 1ns/10ps
// Notes on behaviour
// - mode 3 is default after reset
// - data output undriven after reset
// - decoding starts only at select fall
// - each select fall outside supply reset samples clock idle level
// - supply reset blocks every command
// - standby and ready after initialisation
// - first program/erase waits internal 3 ms
// - address: reserved, 13 page, 10 byte bits
module flash_powerup_if
    import flash_if_pkg::*;
#(
    parameter int unsigned FIRST_WRITE_CYC = FIRST_WRITE_CYCLES
) (
    input  wire logic     clk_sys_i,
    input  wire logic     rstn_i,
    input  wire logic     sck_i,
    input  wire logic     cs_n_i,
    input  wire logic     si_i,
    output logic          so_o,
    output logic          so_oe_o,
    output logic          standby_o,
    output logic          mode3_o,
    output logic          cmd_valid_o,
    output command_s      cmd_o,
    output logic          write_allowed_o
);
    // ----------------------------------------------------------------
    // link domain: clocked by the serial clock, framed by select
    // ----------------------------------------------------------------
    logic [FRAME_BITS-1:0] shreg;
    logic [5:0]            bitcnt;
    logic                  frame_tgl;
    logic [FRAME_BITS-1:0] frame_hold;
    logic [7:0]            out_sh;
    logic                  out_en;
    logic                  link_rstn;
    logic                  mode3_lnk;

    // supply reset (and idle select) holds the link logic in reset
    assign link_rstn = rstn_i & ~cs_n_i;

    // sample input on rising edges; a frame completes on the 32nd bit
    always_ff @(posedge sck_i or negedge link_rstn) begin
        if (!link_rstn) begin
            shreg  <= '0;
            bitcnt <= '0;
        end else begin
            shreg  <= {shreg[FRAME_BITS-2:0], si_i};
            if (bitcnt != 6'(FRAME_BITS)) begin
                bitcnt <= bitcnt + 6'd1;
            end
        end
    end

    // completed frame is held and announced by a toggle
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_tgl  <= 1'b0;
            frame_hold <= '0;
        end else if (!cs_n_i && bitcnt == 6'(FRAME_BITS - 1)) begin
            frame_tgl  <= ~frame_tgl;
            frame_hold <= {shreg[FRAME_BITS-2:0], si_i};
        end
    end

    // status answer shifts out on falling edges after an opcode
    always_ff @(negedge sck_i or negedge link_rstn) begin
        if (!link_rstn) begin
            out_sh <= '0;
            out_en <= 1'b0;
        end else if (bitcnt == 6'(OPCODE_BITS) && shreg[7:0] == OP_READ_STATUS) begin
            out_sh <= STATUS_READY;
            out_en <= 1'b1;
        end else begin
            out_sh <= {out_sh[6:0], 1'b0};
        end
    end

    // mode latched at the select fall from the idle clock level
    always_ff @(negedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode3_lnk <= DEFAULT_MODE3;
        end else begin
            mode3_lnk <= sck_i;
        end
    end

    // ----------------------------------------------------------------
    // crossing into the system clock
    // ----------------------------------------------------------------
    logic tgl_s;
    logic mode0_s;
    logic oe_s;
    logic so_s;
    logic cs_s;
    logic tgl_d;

    sync_bit u_sync_tgl  (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(frame_tgl), .q_o(tgl_s));
    // mode crosses inverted so the synchroniser's reset level already means mode 3
    sync_bit u_sync_mode (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(~mode3_lnk), .q_o(mode0_s));
    sync_bit u_sync_oe   (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(out_en), .q_o(oe_s));
    sync_bit u_sync_so   (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(out_sh[7]), .q_o(so_s));
    sync_bit u_sync_cs   (.clk_i(clk_sys_i), .rstn_i(rstn_i), .d_i(~cs_n_i), .q_o(cs_s));

    // ----------------------------------------------------------------
    // system side: initialisation and first-write delay
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_INIT, ST_STANDBY, ST_BUSY} state_e;

    state_e        state;
    state_e        next_state;
    logic [2:0]    por_cnt;
    logic [2:0]    next_por_cnt;
    logic [DELAY_W-1:0] pw_cnt;
    logic [DELAY_W-1:0] next_pw_cnt;
    logic          pw_done;
    logic          next_pw_done;
    logic          cmd_valid;
    logic          next_cmd_valid;
    command_s      cmd;
    command_s      next_cmd;
    logic          frame_new;

    assign frame_new = tgl_s ^ tgl_d;

    // next-state logic for power-up sequence and command hand-off
    always_comb begin
        next_state     = state;
        next_por_cnt   = por_cnt;
        next_pw_cnt    = pw_cnt;
        next_pw_done   = pw_done;
        next_cmd_valid = 1'b0;
        next_cmd       = cmd;
        if (!pw_done) begin
            if (pw_cnt == DELAY_W'(FIRST_WRITE_CYC - 1)) begin
                next_pw_done = 1'b1;
            end else begin
                next_pw_cnt = pw_cnt + DELAY_W'(1);
            end
        end
        unique case (state)
            ST_INIT: begin
                if (por_cnt == 3'(POR_HOLD_CYCLES - 1)) begin
                    next_state = ST_STANDBY;
                end else begin
                    next_por_cnt = por_cnt + 3'd1;
                end
            end
            ST_STANDBY: begin
                if (frame_new) begin
                    next_cmd.opcode                   = frame_hold[31:24];
                    next_cmd.page_address_bits        = frame_hold[PAGE_MSB:PAGE_LSB];
                    next_cmd.byte_buffer_address_bits = frame_hold[BYTE_MSB:BYTE_LSB];
                    if (is_write_op(frame_hold[31:24]) && !pw_done) begin
                        next_state = ST_BUSY;
                    end else begin
                        next_cmd_valid = 1'b1;
                    end
                end
            end
            ST_BUSY: begin
                if (pw_done) begin
                    next_cmd_valid = 1'b1;
                    next_state     = ST_STANDBY;
                end
            end
        endcase
    end

    // registers of the sequence
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= ST_INIT;
            por_cnt   <= '0;
            pw_cnt    <= '0;
            pw_done   <= 1'b0;
            cmd_valid <= 1'b0;
            cmd       <= '0;
            tgl_d     <= 1'b0;
        end else begin
            state     <= next_state;
            por_cnt   <= next_por_cnt;
            pw_cnt    <= next_pw_cnt;
            pw_done   <= next_pw_done;
            cmd_valid <= next_cmd_valid;
            cmd       <= next_cmd;
            tgl_d     <= tgl_s;
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            so_o            <= 1'b0;
            so_oe_o         <= 1'b0;
            standby_o       <= 1'b0;
            mode3_o         <= DEFAULT_MODE3;
            write_allowed_o <= 1'b0;
        end else begin
            so_o            <= so_s;
            so_oe_o         <= oe_s & cs_s;
            standby_o       <= (state == ST_STANDBY);
            mode3_o         <= ~mode0_s;
            write_allowed_o <= pw_done;
        end
    end

    assign cmd_valid_o = cmd_valid;
    assign cmd_o       = cmd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_oe_reset;
        @(posedge clk_sys_i) $rose(rstn_i) |-> !so_oe_o;
    endproperty
    a_oe_reset: assert property (p_oe_reset) else $error("output driven after reset");

    property p_mode_default;
        @(posedge clk_sys_i) $rose(rstn_i) |-> mode3_o;
    endproperty
    a_mode_default: assert property (p_mode_default) else $error("mode not 3 after reset");

    property p_standby;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            $rose(rstn_i) |-> ##[1:8] standby_o;
    endproperty
    a_standby: assert property (p_standby) else $error("no standby after init");

    property p_no_early_write;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            (cmd_valid && is_write_op(cmd.opcode)) |-> pw_done;
    endproperty
    a_no_early_write: assert property (p_no_early_write) else $error("write before delay");

    property p_cmd_only_standby;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            cmd_valid |-> $past(state) != ST_INIT;
    endproperty
    a_cmd_only_standby: assert property (p_cmd_only_standby) else $error("command during init");

    property p_mode_follow;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            $changed(mode0_s) |=> mode3_o == !$past(mode0_s);
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode not tracked");

    property p_page_field;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            (state == ST_STANDBY && frame_new)
            |=> cmd.page_address_bits == $past(frame_hold[PAGE_MSB:PAGE_LSB]);
    endproperty
    a_page_field: assert property (p_page_field) else $error("page field misplaced");

    property p_oe_needs_select;
        @(posedge clk_sys_i) disable iff (!rstn_i)
            so_oe_o |-> $past(cs_s);
    endproperty
    a_oe_needs_select: assert property (p_oe_needs_select) else $error("drive without select");
endmodule

// File: include/flash_if_pkg.sv
// package: constants and carriers for the serial flash power-up interface
package flash_if_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS          = 50;
    localparam int unsigned FIRST_WRITE_DELAY_US   = 3000;    // 3 ms, longest
    localparam int unsigned FIRST_WRITE_CYCLES     = (FIRST_WRITE_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned POR_HOLD_CYCLES        = 4;
    localparam int unsigned DELAY_W                = 17;

    // ----------------------------------------------------------------
    // frame layout
    // ----------------------------------------------------------------
    localparam int unsigned OPCODE_BITS            = 8;
    localparam int unsigned ADDR_BITS              = 24;
    localparam int unsigned FRAME_BITS             = OPCODE_BITS + ADDR_BITS;
    localparam int unsigned PAGE_MSB               = 22;
    localparam int unsigned PAGE_LSB               = 10;
    localparam int unsigned BYTE_MSB               = 9;
    localparam int unsigned BYTE_LSB               = 0;
    localparam logic        DEFAULT_MODE3          = 1'b1;

    // ----------------------------------------------------------------
    // opcode classes that need the first-write delay, then the status read opcode and its ready value
    // ----------------------------------------------------------------
    localparam logic [7:0]  OP_PAGE_ERASE          = 8'h81;
    localparam logic [7:0]  OP_BLOCK_ERASE         = 8'h50;
    localparam logic [7:0]  OP_SECTOR_ERASE        = 8'h7C;
    localparam logic [7:0]  OP_BUF1_PROG_ERASE     = 8'h83;
    localparam logic [7:0]  OP_BUF2_PROG_ERASE     = 8'h86;
    localparam logic [7:0]  OP_BUF1_PROG           = 8'h88;
    localparam logic [7:0]  OP_BUF2_PROG           = 8'h89;
    localparam logic [7:0]  OP_MEM_PROG_BUF1       = 8'h82;
    localparam logic [7:0]  OP_MEM_PROG_BUF2       = 8'h85;
    localparam logic [7:0]  OP_READ_STATUS         = 8'hD7;
    localparam logic [7:0]  STATUS_READY           = 8'h80;

    typedef struct packed {
        logic [7:0]  opcode;
        logic [12:0] page_address_bits;
        logic [9:0]  byte_buffer_address_bits;
    } command_s;

    function automatic logic is_write_op(input logic [7:0] op);
        return op == OP_PAGE_ERASE || op == OP_BLOCK_ERASE || op == OP_SECTOR_ERASE
            || op == OP_BUF1_PROG_ERASE || op == OP_BUF2_PROG_ERASE || op == OP_BUF1_PROG
            || op == OP_BUF2_PROG || op == OP_MEM_PROG_BUF1 || op == OP_MEM_PROG_BUF2;
    endfunction

endpackage

// File: hdl/sync_bit.sv
// two-stage level synchroniser
`timescale 1ns/10ps
module sync_bit (
    input  wire logic clk_i,
    input  wire logic rstn_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

// File: sim/spi_host_model.sv
// host serial master model that drives select, clock and data into the flash front end
`timescale 1ns/10ps
module spi_host_model #(
    parameter int SELECT_WAIT_NS = 105000
) (
    input  wire logic rstn_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o
);
    realtime rel_t = 0;

    // idle lines: deselected, clock parked high
    initial begin
        sck_o = 1'b1;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end

    // remember when the supply reset last let go
    always @(posedge rstn_i) rel_t = $realtime;

    // one select frame of 32 bits, msb first, clock only inside the frame
    task automatic frame(input logic mode3, input logic [31:0] d);
        sck_o = mode3;
        if (rstn_i && $realtime < rel_t + SELECT_WAIT_NS)
            #(rel_t + SELECT_WAIT_NS - $realtime);
        #32 cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            #32 sck_o = 1'b0;
            si_o = d[i];
            #32 sck_o = 1'b1;
        end
        #32 sck_o = mode3;
        si_o = ~d[0]; // released data line does not keep the last bit
        #32 cs_n_o = 1'b1;
        #400; // deselect long enough for the crossing
    endtask
endmodule

// File: sim/flash_powerup_if_tb_top.sv
// self-checking bench for the flash power-up front end
`timescale 1ns/10ps
module flash_powerup_if_tb_top;
    import flash_if_pkg::*;
    localparam int WR_CYC = 3000;
    logic     clk_sys_i = 1'b0;
    logic     rstn_i = 1'b0;
    logic     sck_i, cs_n_i, si_i, so_o, so_oe_o, standby_o, mode3_o, cmd_valid_o, write_allowed_o;
    command_s cmd_o, got;
    logic     seen;
    int       fail_count = 0;
    int       checked = 0;
    int       cyc = 0;
    int       since_rel = 0;
    int       at_rel = 0;

    flash_powerup_if #(.FIRST_WRITE_CYC(WR_CYC)) uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .si_i(si_i),
        .so_o(so_o), .so_oe_o(so_oe_o), .standby_o(standby_o), .mode3_o(mode3_o),
        .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .write_allowed_o(write_allowed_o));

    spi_host_model host (.rstn_i(rstn_i), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i));

    // system clock, 50 ns
    initial forever #25 clk_sys_i = ~clk_sys_i;

    // cycles since reset release, and the hang guard
    always @(posedge clk_sys_i) begin
        since_rel <= rstn_i ? since_rel + 1 : 0;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // compare one result against its expected value
    task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string what);
        checked++;
        if (act !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s got %h", $time, what, act);
        end
    endtask

    // watch a bounded span for a decoded command
    task automatic wait_cmd(input int lim);
        seen = 1'b0;
        repeat (lim) begin
            @(posedge clk_sys_i);
            if (cmd_valid_o === 1'b1 && !seen) begin
                seen = 1'b1;
                got = cmd_o;
                at_rel = since_rel;
            end
        end
    endtask

    // reset values, then standby soon after release
    task automatic t_reset();
        repeat (6) @(posedge clk_sys_i);
        chk(mode3_o, 1, "mode in reset");
        chk(so_oe_o, 0, "out enable in reset");
        chk(standby_o, 0, "standby in reset");
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        chk(standby_o, 1, "standby");
        $display("test reset done");
    endtask

    // one frame in a given clock mode, fields decoded
    task automatic t_frame(input logic m3, input logic [31:0] d);
        fork
            host.frame(m3, d);
            wait_cmd(2300);
        join
        chk(seen, 1, "command seen");
        chk(mode3_o, m3, "mode pick");
        chk(got, {d[31:24], d[22:0]}, "fields");
        chk(so_oe_o, 0, "out enable idle");
        $display("test frame mode %0d done", m3);
    endtask

    // status opcode: output driven and ready bit shifted out inside the frame
    task automatic t_status();
        logic oe_seen;
        logic hi_seen;
        oe_seen = 1'b0;
        hi_seen = 1'b0;
        fork
            host.frame(1'b0, {OP_READ_STATUS, 24'h00_0000});
            repeat (60) begin
                @(posedge clk_sys_i);
                if (so_oe_o === 1'b1) begin
                    oe_seen = 1'b1;
                end
                if (so_oe_o === 1'b1 && so_o === 1'b1) begin
                    hi_seen = 1'b1;
                end
            end
        join
        chk(oe_seen, 1, "status drive");
        chk(hi_seen, 1, "ready bit out");
        chk(so_oe_o, 0, "released after select");
        $display("test status done");
    endtask

    // commands ignored in reset, first erase held back by the delay
    task automatic t_write();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        fork
            host.frame(1'b0, {8'h55, 24'h00_1234});
            wait_cmd(60);
        join
        chk(seen, 0, "command in reset");
        rstn_i <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
        chk(mode3_o, 1, "mode after reset");
        chk(write_allowed_o, 0, "write early");
        fork
            host.frame(1'b1, {OP_PAGE_ERASE, 1'b0, 13'h0ABC, 10'h155});
            wait_cmd(WR_CYC + 100);
        join
        chk(seen, 1, "erase seen");
        chk(at_rel >= WR_CYC, 1, "erase too soon");
        chk(write_allowed_o, 1, "write allowed");
        $display("test write delay done");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        t_reset();
        t_frame(1'b0, {8'h55, 1'b1, 13'h1FFF, 10'h000});
        t_frame(1'b1, {8'hD2, 1'b0, 13'h0000, 10'h3FF});
        t_status();
        t_write();
        tally_and_finish();
    end
endmodule
